// file: rtl/event_counter.sv
// One 48-bit event counter that adds a per-cycle increment.
// Assumes its inputs are synchronous to the DRAM clock.
`timescale 1ns/1ps

module event_counter
   import memctl_event_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic enable,
   input wire logic clear,
   input wire logic [7:0] inc,
   output logic [`CNT_W-1:0] count
);

   cntState_t s_q;
   cntState_t s_d;

   always_comb begin
      s_d = s_q;
      // Clear wins over counting so software reads a clean zero
      if (clear) begin
         s_d.count = '0;
      end else if (enable) begin
         s_d.count = s_q.count + {{(`CNT_W-8){1'b0}}, inc};
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign count = s_q.count;

endmodule

// file: rtl/memctl_event_pkg.sv
// Types of the event selection and counting block.
// Assumes the constants header sits beside it.
`include "memctl_event_regs.svh"

package memctl_event_pkg;

   typedef struct packed {
      logic en;
      logic [7:0] umask;
      logic [7:0] code;
   } ctlField_t;

   typedef struct packed {
      logic awRdy;
      logic wRdy;
      logic awHave;
      logic wHave;
      logic bVld;
      logic [1:0] bResp;
      logic [`ADDR_W-1:0] awAddr;
      logic [31:0] wData;
      logic [3:0] wStrb;
      logic arRdy;
      logic rVld;
      logic [1:0] rResp;
      logic [31:0] rData;
      ctlField_t [`NUM_PROG-1:0] ctl;
      logic fixEn;
      logic [`NUM_PROG:0] clr;
   } evState_t;

   typedef struct packed {
      logic [`CNT_W-1:0] count;
   } cntState_t;

endpackage

// file: rtl/memctl_event_regs.svh
// Constants of the event selection and counting block.
// Assumes inclusion from the package and the design files by bare name.
//
// Summary of operation
// - Code 0x01 counts activates; mask bit 3 bypass only, b00001011 counts all.
// - Code 0x04 mask bit 0 counts read column commands without auto-precharge.
// - Code 0x04 mask bit 1 counts reads with auto-precharge (closed page only).
// - Mask bit 2 counts fill reads, bit 3 fill reads with precharge.
// - Mask bit 4 counts writes without auto-precharge, bit 5 with it.
// - Mask b00110000 counts all writes; b00111111 counts every column command.
// - Read column counting is never gated by write major mode.
// - Code 0x44 counts precharge-all commands, at most one per cycle.
// - Code 0x45 counts refreshes: bit 0 opportunistic, 1 panic, 2 high priority.
// - Codes 0x10 and 0x20 count read and write pending queue allocations.
// - Codes 0x11 and 0x21 count cycles with a non-empty read or write queue.
// - Codes 0x12, 0x15 and 0x22, 0x16 count per pseudo-channel queue full cycles.
// - Codes 0x80, 0x81 add read queue occupancy, up to 22 per cycle.
// - Codes 0x82, 0x83 add write queue occupancy, up to 40 per cycle.
// - Codes 0x23, 0x24 count write queue match hits for read and write lookups.
// - Codes 0x17 to 0x1a: read buffer inserts, not-empty, full, occupancy.
// - Code 0xd4 counts scoreboard rejects; 0xd5 adds occupancy, up to 128.
// - Codes 0x46, 0x86 count throttled cycles filtered by rank slot mask.
// - Codes 0xe0-0xe3 and 0xe4-0xe7: persistent queue occupancy, not-empty, full, inserts.
// - Code 0xd3 counts scoreboard tag checks.
// - Four programmable and one fixed counter, all 48 bits; programmable ones take any event, the fixed one counts DRAM clocks.
// - Counting runs on the DRAM clock.
`ifndef MEMCTL_EVENT_REGS_SVH
`define MEMCTL_EVENT_REGS_SVH

`define CNT_W 48
`define NUM_PROG 4
`define ADDR_W 8

// Register byte offsets
`define OFS_CTL0 8'h00
`define OFS_FIX_CTL 8'h10
`define OFS_CTR0_LO 8'h20
`define OFS_FIX_LO 8'h40
`define OFS_FIX_HI 8'h44

// Control register fields
`define CTL_CODE_LSB 0
`define CTL_MASK_LSB 8
`define CTL_CLR_BIT 19
`define CTL_EN_BIT 22
`define CTL_RESET 32'h00000000

// Event codes
`define EV_CLOCKTICKS 8'h00
`define EV_ACTIVATE 8'h01
`define EV_COLUMN 8'h04
`define EV_RPQ_INSERT 8'h10
`define EV_RPQ_NE 8'h11
`define EV_RPQ_FULL_PC0 8'h12
`define EV_RPQ_FULL_PC1 8'h15
`define EV_WPQ_FULL_PC1 8'h16
`define EV_RDB_INSERT 8'h17
`define EV_RDB_NE 8'h18
`define EV_RDB_FULL 8'h19
`define EV_RDB_OCC 8'h1A
`define EV_WPQ_INSERT 8'h20
`define EV_WPQ_NE 8'h21
`define EV_WPQ_FULL_PC0 8'h22
`define EV_WPQ_READ_HIT 8'h23
`define EV_WPQ_WRITE_HIT 8'h24
`define EV_PRE_ALL 8'h44
`define EV_REFRESH 8'h45
`define EV_THROTTLE 8'h46
`define EV_RPQ_OCC_PC0 8'h80
`define EV_RPQ_OCC_PC1 8'h81
`define EV_WPQ_OCC_PC0 8'h82
`define EV_WPQ_OCC_PC1 8'h83
`define EV_CRIT_THROTTLE 8'h86
`define EV_TAG_CHECK 8'hD3
`define EV_SB_REJECT 8'hD4
`define EV_SB_OCC 8'hD5
`define EV_PMM_RD_OCC 8'hE0
`define EV_PMM_RD_NE 8'hE1
`define EV_PMM_RD_FULL 8'hE2
`define EV_PMM_RD_INSERT 8'hE3
`define EV_PMM_WR_OCC 8'hE4
`define EV_PMM_WR_NE 8'hE5
`define EV_PMM_WR_FULL 8'hE6
`define EV_PMM_WR_INSERT 8'hE7

// Unit mask bit positions
`define UM_ACT_BYPASS 3
`define UM_RD 0
`define UM_RD_PRE 1
`define UM_FILL 2
`define UM_FILL_PRE 3
`define UM_WR 4
`define UM_WR_PRE 5
`define UM_REF_OPP 0
`define UM_REF_PANIC 1
`define UM_REF_HIGH 2

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// file: rtl/memctl_event_select_counting.sv
// Event selection and counting for one memory channel's performance monitor.
// Assumes inputs synchronous to mclk and one bus write and read in flight at most.
//
// The AXI4-Lite slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps

module memctl_event_select_counting
   import memctl_event_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   // AXI4-Lite slave
   input wire logic [`ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [`ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Command strobes from the scheduler
   input wire logic actIssue,
   input wire logic actBypass,
   input wire logic rdCas,
   input wire logic rdCasPre,
   input wire logic rdFill,
   input wire logic rdFillPre,
   input wire logic wrCas,
   input wire logic wrCasPre,
   input wire logic preAll,
   input wire logic refOpp,
   input wire logic refPanic,
   input wire logic refHigh,
   // Pending queues
   input wire logic rpqInsert,
   input wire logic [4:0] rpqOcc0,
   input wire logic [4:0] rpqOcc1,
   input wire logic rpqFull0,
   input wire logic rpqFull1,
   input wire logic wpqInsert,
   input wire logic [5:0] wpqOcc0,
   input wire logic [5:0] wpqOcc1,
   input wire logic wpqFull0,
   input wire logic wpqFull1,
   input wire logic wpqReadHit,
   input wire logic wpqWriteHit,
   // Read data buffer
   input wire logic rdbInsert,
   input wire logic rdbNotEmpty,
   input wire logic rdbFull,
   input wire logic rdbOccStep,
   // Scoreboard
   input wire logic sbTagCheck,
   input wire logic sbReject,
   input wire logic [7:0] sbOcc,
   // Throttling per rank slot
   input wire logic [1:0] throttleSlot,
   input wire logic [1:0] critThrottleSlot,
   // Persistent memory queues
   input wire logic [7:0] pmmRdOcc,
   input wire logic pmmRdFull,
   input wire logic pmmRdInsert,
   input wire logic [7:0] pmmWrOcc,
   input wire logic pmmWrFull,
   input wire logic pmmWrInsert
);

   ////////////////////////////////////////////////////////////////////////////
   // State

   evState_t s_q;
   evState_t s_d;
   logic [`CNT_W-1:0] cnt [`NUM_PROG:0];
   logic [7:0] inc [`NUM_PROG:0];
   logic [`NUM_PROG:0] cntEn;

   ////////////////////////////////////////////////////////////////////////////
   // Event selection

   function automatic logic [7:0] one(input logic b);
      one = {7'h00, b};
   endfunction

   function automatic logic [7:0] eventInc(input logic [7:0] code, input logic [7:0] um);
      eventInc = 8'h00;
      case (code)
         `EV_CLOCKTICKS: eventInc = 8'h01;
         `EV_ACTIVATE: eventInc = one(actIssue
            & ((um[`UM_ACT_BYPASS] & actBypass) | ((um[0] | um[1]) & ~actBypass)));
         // No major-mode input: reads count in either mode
         `EV_COLUMN: eventInc = one((um[`UM_RD] & rdCas)
            | (um[`UM_RD_PRE] & rdCasPre)
            | (um[`UM_FILL] & rdFill) | (um[`UM_FILL_PRE] & rdFillPre)
            | (um[`UM_WR] & wrCas) | (um[`UM_WR_PRE] & wrCasPre));
         `EV_PRE_ALL: eventInc = one(preAll);
         `EV_REFRESH: eventInc = one((um[`UM_REF_OPP] & refOpp)
            | (um[`UM_REF_PANIC] & refPanic) | (um[`UM_REF_HIGH] & refHigh));
         `EV_RPQ_INSERT: eventInc = one(rpqInsert);
         `EV_WPQ_INSERT: eventInc = one(wpqInsert);
         `EV_RPQ_NE: eventInc = one((|rpqOcc0) | (|rpqOcc1));
         `EV_WPQ_NE: eventInc = one((|wpqOcc0) | (|wpqOcc1));
         `EV_RPQ_FULL_PC0: eventInc = one(rpqFull0);
         `EV_RPQ_FULL_PC1: eventInc = one(rpqFull1);
         `EV_WPQ_FULL_PC0: eventInc = one(wpqFull0);
         `EV_WPQ_FULL_PC1: eventInc = one(wpqFull1);
         `EV_RPQ_OCC_PC0: eventInc = {3'h0, rpqOcc0};
         `EV_RPQ_OCC_PC1: eventInc = {3'h0, rpqOcc1};
         `EV_WPQ_OCC_PC0: eventInc = {2'h0, wpqOcc0};
         `EV_WPQ_OCC_PC1: eventInc = {2'h0, wpqOcc1};
         `EV_WPQ_READ_HIT: eventInc = one(wpqReadHit);
         `EV_WPQ_WRITE_HIT: eventInc = one(wpqWriteHit);
         `EV_RDB_INSERT: eventInc = one(rdbInsert);
         `EV_RDB_NE: eventInc = one(rdbNotEmpty);
         `EV_RDB_FULL: eventInc = one(rdbFull);
         `EV_RDB_OCC: eventInc = one(rdbOccStep);
         `EV_SB_REJECT: eventInc = one(sbReject);
         `EV_SB_OCC: eventInc = sbOcc;
         // Several slots throttled at once still add only one
         `EV_THROTTLE: eventInc = one(|(um[1:0] & throttleSlot));
         `EV_CRIT_THROTTLE: eventInc = one(|(um[1:0] & critThrottleSlot));
         `EV_PMM_RD_OCC: eventInc = pmmRdOcc;
         `EV_PMM_RD_NE: eventInc = one(|pmmRdOcc);
         `EV_PMM_RD_FULL: eventInc = one(pmmRdFull);
         `EV_PMM_RD_INSERT: eventInc = one(pmmRdInsert);
         `EV_PMM_WR_OCC: eventInc = pmmWrOcc;
         `EV_PMM_WR_NE: eventInc = one(|pmmWrOcc);
         `EV_PMM_WR_FULL: eventInc = one(pmmWrFull);
         `EV_PMM_WR_INSERT: eventInc = one(pmmWrInsert);
         `EV_TAG_CHECK: eventInc = one(sbTagCheck);
         default: eventInc = 8'h00;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Counters

   always_comb begin
      for (int i = 0; i < `NUM_PROG; i++) begin
         inc[i] = eventInc(s_q.ctl[i].code, s_q.ctl[i].umask);
         cntEn[i] = s_q.ctl[i].en;
      end
      // Fixed counter always counts DRAM clocks
      inc[`NUM_PROG] = 8'h01;
      cntEn[`NUM_PROG] = s_q.fixEn;
   end

   genvar g;
   generate
      for (g = 0; g <= `NUM_PROG; g++) begin : gCnt
         event_counter uCnt (
            .mclk(mclk),
            .rst(rst),
            .enable(cntEn[g]),
            .clear(s_q.clr[g]),
            .inc(inc[g]),
            .count(cnt[g])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Register read decode

   function automatic logic [31:0] ctlWord(input ctlField_t c);
      ctlWord = `CTL_RESET;
      ctlWord[`CTL_CODE_LSB +: 8] = c.code;
      ctlWord[`CTL_MASK_LSB +: 8] = c.umask;
      ctlWord[`CTL_EN_BIT] = c.en;
   endfunction

   // Answers {hit, data}; counter high words carry bits 47:32 in the low half
   function automatic logic [32:0] readWord(input logic [`ADDR_W-1:0] a);
      readWord = {1'b0, 32'h00000000};
      for (int i = 0; i < `NUM_PROG; i++) begin
         if (a == (`OFS_CTL0 + 8'(4 * i))) begin
            readWord = {1'b1, ctlWord(s_q.ctl[i])};
         end
         if (a == (`OFS_CTR0_LO + 8'(8 * i))) begin
            readWord = {1'b1, cnt[i][31:0]};
         end
         if (a == (`OFS_CTR0_LO + 8'(8 * i + 4))) begin
            readWord = {1'b1, 16'h0000, cnt[i][`CNT_W-1:32]};
         end
      end
      if (a == `OFS_FIX_CTL) begin
         readWord = {1'b1, 9'h000, s_q.fixEn, 22'h000000};
      end
      if (a == `OFS_FIX_LO) begin
         readWord = {1'b1, cnt[`NUM_PROG][31:0]};
      end
      if (a == `OFS_FIX_HI) begin
         readWord = {1'b1, 16'h0000, cnt[`NUM_PROG][`CNT_W-1:32]};
      end
   endfunction

   // A read-only address is still mapped, so only truly unknown ones fail
   function automatic logic mapped(input logic [`ADDR_W-1:0] a);
      mapped = readWord(a)[32];
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      logic [31:0] wd;
      wd = s_q.wData;
      s_d = s_q;
      // Clears pulse one cycle
      s_d.clr = '0;

      if (awvalid && s_q.awRdy) begin
         s_d.awAddr = awaddr;
         s_d.awHave = 1'b1;
         s_d.awRdy = 1'b0;
      end
      if (wvalid && s_q.wRdy) begin
         s_d.wData = wdata;
         s_d.wStrb = wstrb;
         s_d.wHave = 1'b1;
         s_d.wRdy = 1'b0;
      end

      // Apply once address and data are held
      if (s_q.awHave && s_q.wHave && !s_q.bVld) begin
         s_d.awHave = 1'b0;
         s_d.wHave = 1'b0;
         s_d.bVld = 1'b1;
         s_d.bResp = mapped(s_q.awAddr) ? `RESP_OKAY : `RESP_SLVERR;
         for (int i = 0; i < `NUM_PROG; i++) begin
            if (s_q.awAddr == (`OFS_CTL0 + 8'(4 * i))) begin
               if (s_q.wStrb[0]) begin
                  s_d.ctl[i].code = wd[`CTL_CODE_LSB +: 8];
               end
               if (s_q.wStrb[1]) begin
                  s_d.ctl[i].umask = wd[`CTL_MASK_LSB +: 8];
               end
               if (s_q.wStrb[2]) begin
                  s_d.ctl[i].en = wd[`CTL_EN_BIT];
                  s_d.clr[i] = wd[`CTL_CLR_BIT];
               end
            end
         end
         if (s_q.awAddr == `OFS_FIX_CTL && s_q.wStrb[2]) begin
            s_d.fixEn = wd[`CTL_EN_BIT];
            s_d.clr[`NUM_PROG] = wd[`CTL_CLR_BIT];
         end
      end

      if (s_q.bVld && bready) begin
         s_d.bVld = 1'b0;
         s_d.awRdy = 1'b1;
         s_d.wRdy = 1'b1;
      end

      // Read data is sampled at acceptance, so a count is a single snapshot
      if (arvalid && s_q.arRdy) begin
         s_d.arRdy = 1'b0;
         s_d.rVld = 1'b1;
         s_d.rData = readWord(araddr)[31:0];
         s_d.rResp = mapped(araddr) ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (s_q.rVld && rready) begin
         s_d.rVld = 1'b0;
         s_d.arRdy = 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         s_q <= '0;
         s_q.awRdy <= 1'b1;
         s_q.wRdy <= 1'b1;
         s_q.arRdy <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign awready = s_q.awRdy;
   assign wready = s_q.wRdy;
   assign bvalid = s_q.bVld;
   assign bresp = s_q.bResp;
   assign arready = s_q.arRdy;
   assign rvalid = s_q.rVld;
   assign rdata = s_q.rData;
   assign rresp = s_q.rResp;

endmodule

// file: verif/event_source_model.sv
// Behavioural scheduler and queue side driving event signals.
// Assumes one burst at a time: start for one cycle, then wait while busy.
`timescale 1ns/1ps

module event_source_model #(
   parameter int LEN = 6
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic start,
   input wire logic [33:0] vec,
   input wire logic [2:0] sel,
   input wire logic [7:0] occ,
   output logic busy,
   output logic [33:0] ev,
   output logic [4:0] rpqOcc0,
   output logic [4:0] rpqOcc1,
   output logic [5:0] wpqOcc0,
   output logic [5:0] wpqOcc1,
   output logic [7:0] sbOcc,
   output logic [7:0] pmmRdOcc,
   output logic [7:0] pmmWrOcc
);
   logic [7:0] left_q;
   logic [33:0] ev_q;
   logic [2:0] sel_q;
   logic [7:0] occ_q;

   // Strobes and levels idle again after a burst, as queues drain
   always_ff @(posedge mclk) begin
      if (rst) begin
         left_q <= 8'h00;
         ev_q <= 34'h0;
         sel_q <= 3'h7;
         occ_q <= 8'h00;
      end else if (start) begin
         left_q <= 8'(LEN);
         ev_q <= vec;
         sel_q <= sel;
         occ_q <= occ;
      end else if (left_q > 8'h01) begin
         left_q <= left_q - 8'h01;
      end else begin
         left_q <= 8'h00;
         ev_q <= 34'h0;
         occ_q <= 8'h00;
      end
   end

   assign busy = left_q != 8'h00;
   assign ev = ev_q;
   assign rpqOcc0 = sel_q == 3'h0 ? occ_q[4:0] : 5'h00;
   assign rpqOcc1 = sel_q == 3'h1 ? occ_q[4:0] : 5'h00;
   assign wpqOcc0 = sel_q == 3'h2 ? occ_q[5:0] : 6'h00;
   assign wpqOcc1 = sel_q == 3'h3 ? occ_q[5:0] : 6'h00;
   assign sbOcc = sel_q == 3'h4 ? occ_q : 8'h00;
   assign pmmRdOcc = sel_q == 3'h5 ? occ_q : 8'h00;
   assign pmmWrOcc = sel_q == 3'h6 ? occ_q : 8'h00;
endmodule

// file: verif/memctl_event_chk.sv
// Register bus checker of the event counting block.
// Bound to the top module; sees only its ports.
`timescale 1ns/1ps
`include "memctl_event_regs.svh"

module memctl_event_chk
   import memctl_event_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic [`ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic [`ADDR_W-1:0] araddr,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   input wire logic rready
);
   logic [`ADDR_W-1:0] rdAddr_q;
   logic [`ADDR_W-1:0] wrAddr_q;

   // Aligned mapped words
   function automatic logic mapped(input logic [7:0] a);
      return a[1:0] == 2'h0 && (a <= 8'h10 || (a >= 8'h20 && a <= 8'h44));
   endfunction

   always_ff @(posedge mclk) begin
      if (arvalid && arready) begin
         rdAddr_q <= araddr;
      end
      if (awvalid && awready) begin
         wrAddr_q <= awaddr;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);

   chk_read_answer: assert property (arvalid && arready |=> rvalid && !arready)
      else $error("read answer not one cycle after address");
   chk_read_done: assert property (rvalid && rready |=> !rvalid && arready)
      else $error("read channel not released after handshake");
   chk_write_answer: assert property (awvalid && awready && wvalid && wready
      |=> !awready && !wready ##1 bvalid)
      else $error("write response not two cycles after take");
   chk_write_done: assert property (bvalid && bready |=> !bvalid && awready && wready)
      else $error("write channel not released after handshake");
   chk_hi_zero: assert property (rvalid && rdAddr_q >= 8'h20 && rdAddr_q[2]
      |-> rdata[31:16] == 16'h0000)
      else $error("counter upper word wider than 48 bits");
   chk_ctl_layout: assert property (rvalid && rdAddr_q[7:4] == 4'h0 && rdAddr_q[1:0] == 2'h0
      |-> rdata[31:23] == 9'h000 && rdata[21:16] == 6'h00)
      else $error("control word shows clear or spare bits");
   chk_read_err: assert property (rvalid && rdAddr_q[1:0] == 2'h0 && !mapped(rdAddr_q)
      |-> rresp == `RESP_SLVERR && rdata == 32'h00000000)
      else $error("unmapped read not refused");
   chk_read_okay: assert property (rvalid && mapped(rdAddr_q) |-> rresp == `RESP_OKAY)
      else $error("mapped read refused");
   chk_write_resp: assert property (bvalid
      |-> bresp == (mapped(wrAddr_q) ? `RESP_OKAY : `RESP_SLVERR))
      else $error("write response code wrong");
endmodule

bind memctl_event_select_counting memctl_event_chk chk (
   .mclk(mclk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
   .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
   .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
   .rvalid(rvalid), .rready(rready)
);

// file: verif/testbench.sv
// Self-checking bench: bus tasks and event bursts.
// Assumes package, checker and source model compile first.
`timescale 1ns/1ps
`include "memctl_event_regs.svh"

module testbench;
   localparam int LEN = 6;
   logic mclk = 1'h0;
   logic rst = 1'h1;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00, occ = 8'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic [3:0] wstrb = 4'h0;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic awready, wready, bvalid, arready, rvalid, busy;
   logic [1:0] bresp, rresp;
   logic start = 1'h0;
   logic [33:0] vec = 34'h0, ev;
   logic [2:0] sel = 3'h7;
   logic [4:0] rq0, rq1;
   logic [5:0] wq0, wq1;
   logic [7:0] sbo, prd, pwr;
   int n_fail = 0, n_tests = 0, cyc = 0, ctr = 0;

   always #12.5 mclk = ~mclk;
   always @(posedge mclk) cyc <= cyc + 1;

   event_source_model #(.LEN(LEN)) src (.mclk(mclk), .rst(rst), .start(start), .vec(vec),
      .sel(sel), .occ(occ), .busy(busy), .ev(ev), .rpqOcc0(rq0), .rpqOcc1(rq1),
      .wpqOcc0(wq0), .wpqOcc1(wq1), .sbOcc(sbo), .pmmRdOcc(prd), .pmmWrOcc(pwr));

   memctl_event_select_counting DUT (.mclk(mclk), .rst(rst), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .actIssue(ev[0]), .actBypass(ev[1]), .rdCas(ev[2]), .rdCasPre(ev[3]),
      .rdFill(ev[4]), .rdFillPre(ev[5]), .wrCas(ev[6]), .wrCasPre(ev[7]), .preAll(ev[8]),
      .refOpp(ev[9]), .refPanic(ev[10]), .refHigh(ev[11]), .rpqInsert(ev[12]),
      .rpqOcc0(rq0), .rpqOcc1(rq1), .rpqFull0(ev[13]), .rpqFull1(ev[14]),
      .wpqInsert(ev[15]), .wpqOcc0(wq0), .wpqOcc1(wq1), .wpqFull0(ev[16]),
      .wpqFull1(ev[17]), .wpqReadHit(ev[18]), .wpqWriteHit(ev[19]), .rdbInsert(ev[20]),
      .rdbNotEmpty(ev[21]), .rdbFull(ev[22]), .rdbOccStep(ev[23]), .sbTagCheck(ev[24]),
      .sbReject(ev[25]), .sbOcc(sbo), .throttleSlot(ev[31:30]),
      .critThrottleSlot(ev[33:32]), .pmmRdOcc(prd), .pmmRdFull(ev[26]),
      .pmmRdInsert(ev[27]), .pmmWrOcc(pwr), .pmmWrFull(ev[28]), .pmmWrInsert(ev[29]));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic timeout(input string nm);
      n_fail++;
      $display("mismatch %s expected answer seen none", nm);
      final_report();
   endtask

   task automatic chk_val(input string nm, input logic [47:0] e, input logic [47:0] g);
      n_tests++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch %s expected %0h seen %0h", nm, e, g);
      end
   endtask

   task automatic chk_resp(input string nm, input logic [1:0] e, input logic [1:0] g);
      n_tests++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch %s expected %0h seen %0h", nm, e, g);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int k = 0;
      @(posedge mclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hF;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do begin
         @(posedge mclk);
         k++;
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
      end while (!(bvalid && bready) && k < 40);
      if (k >= 40) timeout("write");
      r = bresp;
      bready <= 1'h0;
   endtask

   // Take cycle returned to judge free-running counts
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r,
         output int t);
      int k = 0;
      @(posedge mclk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do begin
         @(posedge mclk);
         k++;
         if (arvalid && arready) t = cyc;
         if (arready) arvalid <= 1'h0;
      end while (!(rvalid && rready) && k < 40);
      if (k >= 40) timeout("read");
      d = rdata;
      r = rresp;
      rready <= 1'h0;
   endtask

   task automatic run(input logic [7:0] code, input logic [7:0] um, input int b1, input int b2,
         input logic [2:0] s, input logic [7:0] o, input int inc);
      logic [1:0] r;
      logic [31:0] hi, lo;
      logic [7:0] c;
      int k = 0, t;
      c = 8'(4 * ctr);
      wr(c, {12'h000, 1'h1, 3'h0, um, code}, r);
      wr(c, {9'h000, 1'h1, 6'h00, um, code}, r);
      @(posedge mclk);
      vec <= (b1 >= 0 ? 34'h1 << b1 : 34'h0) | (b2 >= 0 ? 34'h1 << b2 : 34'h0);
      sel <= s;
      occ <= o;
      start <= 1'h1;
      @(posedge mclk);
      start <= 1'h0;
      do begin
         @(posedge mclk);
         k++;
      end while (busy && k < 40);
      if (k >= 40) timeout("burst");
      rd(8'h24 + 8'(8 * ctr), hi, r, t);
      rd(8'h20 + 8'(8 * ctr), lo, r, t);
      chk_val($sformatf("event %0h", code), 48'(LEN * inc), {hi[15:0], lo});
      ctr = (ctr + 1) % 4;
   endtask

   task automatic pulse(input logic [7:0] code, input logic [7:0] um, input int b, input int i);
      run(code, um, b, -1, 3'h7, 8'h00, i);
   endtask

   task automatic lvl(input logic [7:0] code, input logic [2:0] s, input logic [7:0] o,
         input int i);
      run(code, 8'h01, -1, -1, s, o, i);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [31:0] d, d2;
      logic [1:0] r;
      int t1, t2;
      repeat (10) @(posedge mclk);
      rst <= 1'h0;
      rd(8'h00, d, r, t1);
      chk_val("control reset", 48'h0, 48'(d));
      wr(8'h04, 32'hFFFFFFFF, r);
      rd(8'h04, d, r, t1);
      chk_val("control readback", 48'h40FFFF, 48'(d));
      wr(8'h14, 32'h00000001, r);
      chk_resp("unmapped write", `RESP_SLVERR, r);
      rd(8'h80, d, r, t1);
      chk_resp("unmapped read", `RESP_SLVERR, r);
      wr(8'h20, 32'h00001234, r);
      chk_resp("counter write", `RESP_OKAY, r);
      wr(8'h10, 32'h00400000, r);
      rd(8'h40, d, r, t1);
      rd(8'h40, d2, r, t2);
      chk_val("fixed step", 48'(t2 - t1), 48'(d2 - d));
      wr(8'h10, 32'h00000000, r);
      rd(8'h40, d, r, t1);
      rd(8'h40, d2, r, t2);
      chk_val("fixed hold", 48'h0, 48'(d2 - d));
      wr(8'h10, 32'h00080000, r);
      rd(8'h40, d, r, t1);
      chk_val("fixed clear", 48'h0, 48'(d));
      pulse(8'h01, 8'h0B, 0, 1);
      pulse(8'h01, 8'h08, 0, 0);
      run(8'h01, 8'h08, 0, 1, 3'h7, 8'h00, 1);
      pulse(8'h01, 8'h00, 0, 0);
      pulse(8'h04, 8'h01, 2, 1);
      pulse(8'h04, 8'h01, 6, 0);
      pulse(8'h04, 8'h02, 3, 1);
      pulse(8'h04, 8'h04, 4, 1);
      pulse(8'h04, 8'h08, 5, 1);
      pulse(8'h04, 8'h0F, 4, 1);
      pulse(8'h04, 8'h10, 6, 1);
      pulse(8'h04, 8'h20, 7, 1);
      pulse(8'h04, 8'h30, 7, 1);
      pulse(8'h04, 8'h3F, 2, 1);
      pulse(8'h44, 8'h01, 8, 1);
      pulse(8'h45, 8'h01, 9, 1);
      pulse(8'h45, 8'h02, 10, 1);
      pulse(8'h45, 8'h04, 11, 1);
      pulse(8'h10, 8'h01, 12, 1);
      pulse(8'h20, 8'h01, 15, 1);
      lvl(8'h11, 3'h0, 8'h03, 1);
      lvl(8'h21, 3'h3, 8'h05, 1);
      pulse(8'h12, 8'h01, 13, 1);
      pulse(8'h15, 8'h01, 14, 1);
      pulse(8'h22, 8'h01, 16, 1);
      pulse(8'h16, 8'h01, 17, 1);
      pulse(8'h12, 8'h01, 14, 0);
      lvl(8'h80, 3'h0, 8'h16, 22);
      lvl(8'h81, 3'h1, 8'h16, 22);
      lvl(8'h82, 3'h2, 8'h28, 40);
      lvl(8'h83, 3'h3, 8'h28, 40);
      pulse(8'h23, 8'h01, 18, 1);
      pulse(8'h24, 8'h01, 19, 1);
      pulse(8'h17, 8'h01, 20, 1);
      pulse(8'h18, 8'h01, 21, 1);
      pulse(8'h19, 8'h01, 22, 1);
      pulse(8'h1A, 8'h01, 23, 1);
      pulse(8'hD4, 8'h01, 25, 1);
      lvl(8'hD5, 3'h4, 8'h80, 128);
      pulse(8'h46, 8'h01, 30, 1);
      pulse(8'h46, 8'h02, 30, 0);
      pulse(8'h86, 8'h02, 33, 1);
      lvl(8'hE0, 3'h5, 8'hC8, 200);
      lvl(8'hE1, 3'h5, 8'h09, 1);
      pulse(8'hE2, 8'h01, 26, 1);
      pulse(8'hE3, 8'h01, 27, 1);
      lvl(8'hE4, 3'h6, 8'h4D, 77);
      lvl(8'hE5, 3'h6, 8'h01, 1);
      pulse(8'hE6, 8'h01, 28, 1);
      pulse(8'hE7, 8'h01, 29, 1);
      pulse(8'hD3, 8'h01, 24, 1);
      final_report();
   end
endmodule
